// ---- rtl/cgs_defines.svh ----
// register addresses, field positions, reset words and timing counts of the
// clock generator configuration block; assumes nothing beyond the preprocessor
`ifndef CGS_DEFINES_SVH
`define CGS_DEFINES_SVH

// register addresses carried in the low five bits of each serial word
`define CGS_ADDR_OSC_OUT 5'h0a
`define CGS_ADDR_SYNC_XTAL 5'h0b
`define CGS_ADDR_LOCK_PIN 5'h0c
`define CGS_ADDR_RB_GP0 5'h0d
`define CGS_ADDR_GP1 5'h0e
`define CGS_ADDR_FIXED 5'h10
`define CGS_ADDR_LOOP_FILT 5'h18
`define CGS_ADDR_LOCK_CNT 5'h1a

// register slots in the local array
`define CGS_IDX_OSC 0
`define CGS_IDX_SYNC 1
`define CGS_IDX_LOCK 2
`define CGS_IDX_RB 3
`define CGS_IDX_GP1 4
`define CGS_IDX_FIXED 5
`define CGS_IDX_LF 6
`define CGS_IDX_CNT 7

// field positions
`define CGS_OSC1_BYPASS_BIT 21
`define CGS_OSC0_BYPASS_BIT 20
`define CGS_OSC_DIV_MSB 18
`define CGS_OSC_DIV_LSB 16
`define CGS_GRP_EXCL_LSB 20
`define CGS_SYNC_POL_BIT 16
`define CGS_SYNC_TYPE_MSB 13
`define CGS_SYNC_TYPE_LSB 12
`define CGS_XTAL_EN_BIT 5
`define CGS_LOCK_SRC_MSB 31
`define CGS_LOCK_SRC_LSB 27
`define CGS_PIN_TYPE_MSB 26
`define CGS_PIN_TYPE_LSB 24
`define CGS_HOLD_SYNC_BIT 23
`define CGS_GP0_MSB 18
`define CGS_GP0_LSB 16
`define CGS_CAP4_MSB 31
`define CGS_CAP4_LSB 28
`define CGS_CAP3_MSB 27
`define CGS_CAP3_LSB 24
`define CGS_LOCK_CNT_MSB 19
`define CGS_LOCK_CNT_LSB 6

// codes
`define CGS_CAP_MAX 4'h0d
`define CGS_SRC_LOW 5'h00
`define CGS_SRC_DLD 5'h02
`define CGS_SRC_N 5'h0d
`define CGS_SRC_N_HALF 5'h0e
`define CGS_SRC_R 5'h11
`define CGS_SRC_R_HALF 5'h12
`define CGS_TYPE_PP 3'h3
`define CGS_TYPE_PP_INV 3'h4
`define CGS_TYPE_OPEN_SRC 3'h5
`define CGS_TYPE_OPEN_DRN 3'h6
`define CGS_SYNC_PULL_UP 2'h1
`define CGS_SYNC_PULL_DOWN 2'h2
`define CGS_GP_WEAK_PD 3'h2
`define CGS_GP_LOW 3'h3
`define CGS_GP_HIGH 3'h4

// synchroniser slots of the sampled pins
`define CGS_PIN_OSC 0
`define CGS_PIN_SYNC 1
`define CGS_PIN_REF 2
`define CGS_PIN_FB 3
`define CGS_PIN_LATCH 4

// reset words
`define CGS_RST_OSC 32'h0000_000a
`define CGS_RST_SYNC 32'h0000_000b
`define CGS_RST_LOCK 32'h0300_000c
`define CGS_RST_RB 32'h0303_000d
`define CGS_RST_GP1 32'h0300_000e
`define CGS_RST_FIXED 32'h0000_0010
`define CGS_RST_LF 32'h0000_0018
`define CGS_RST_CNT 32'h0000_011a

// phase error window of the lock detector
`define CGS_CLK_NS 20
`define CGS_LOCK_WIN_NS 40
`define CGS_LOCK_WIN_CYC (`CGS_LOCK_WIN_NS / `CGS_CLK_NS)

`endif

// ---- rtl/cgs_pkg.sv ----
// types of the clock generator configuration block
// assumes cgs_defines.svh is on the include path
package cgs_pkg;
`include "cgs_defines.svh"

    typedef enum logic [0:0] {DLD_IDLE, DLD_WAIT} cgs_dld_st_t;

    // all state of the system clock domain
    typedef struct packed {
        logic [4:0] pin_s1;
        logic [4:0] pin_s2;
        logic [4:0] pin_prev;
        logic [7:0][31:0] regs;
        logic [3:0] osc_cnt;
        logic osc_div;
        logic [1:0] osc_out;
        logic [5:0] grp;
        logic sync_act;
        logic sync_pu;
        logic sync_pd;
        logic xtal_en;
        cgs_dld_st_t dld_st;
        logic [3:0] win_cnt;
        logic [3:0] fb_age;
        logic [13:0] good_cnt;
        logic lock;
        logic n_half;
        logic r_half;
        logic lock_pin;
        logic lock_oe;
        logic rb_pin;
        logic rb_oe;
        logic [1:0] gp_pin;
        logic [1:0] gp_oe;
        logic [1:0] gp_pd;
        logic [3:0] cap4;
        logic [3:0] cap3;
    } cgs_core_t;

    // all state of the serial link domain
    typedef struct packed {
        logic [31:0] shreg;
    } cgs_link_t;
endpackage

// ---- rtl/cgs_top.sv ----
// configuration and control logic of a clock generator behind a three-wire serial port
// assumes the host stops the serial clock while the latch pin is high, and that
// the oscillator, sync, reference and feedback pins are slow against mclk_i
`timescale 1ns/100ps
`include "cgs_defines.svh"

module cgs_top (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic serial_latch_i,
    input wire logic osc_in_i,
    input wire logic sync_pin_i,
    input wire logic pll_ref_i,
    input wire logic pll_fb_i,
    output logic [1:0] osc_out_o,
    output logic [5:0] group_clk_o,
    output logic sync_pull_up_o,
    output logic sync_pull_down_o,
    output logic crystal_amp_enable_o,
    output logic digital_lock_detect_o,
    output logic test_lock_pin_o,
    output logic test_lock_pin_oe_o,
    output logic readback_pin_o,
    output logic readback_pin_oe_o,
    output logic [1:0] general_out_o,
    output logic [1:0] general_out_oe_o,
    output logic [1:0] general_out_pulldown_o,
    output logic [3:0] filter_cap_fourth_select_o,
    output logic [3:0] filter_cap_third_select_o
);
    import cgs_pkg::*;

    localparam logic [7:0][4:0] REG_ADDR = {`CGS_ADDR_LOCK_CNT, `CGS_ADDR_LOOP_FILT,
        `CGS_ADDR_FIXED, `CGS_ADDR_GP1, `CGS_ADDR_RB_GP0, `CGS_ADDR_LOCK_PIN,
        `CGS_ADDR_SYNC_XTAL, `CGS_ADDR_OSC_OUT};
    localparam logic [3:0] WIN_CYC = 4'(`CGS_LOCK_WIN_CYC);

    cgs_core_t q_r;
    cgs_core_t q_nxt;
    cgs_link_t lk_r;
    cgs_link_t lk_nxt;
    logic [4:0] rise;
    logic good;
    logic bad;
    logic [3:0] div_n;
    logic [1:0] pin_drv;
    logic [2:0] gp_drv;
    logic lock_src_val;
    logic [13:0] cnt_cfg;

    // divide ratio of the oscillator output divider
    function automatic logic [3:0] osc_div_of(input logic [2:0] code);
        case (code)
            3'h0: osc_div_of = 4'h8;
            3'h1, 3'h2: osc_div_of = 4'h2;
            default: osc_div_of = {1'b0, code};
        endcase
    endfunction

    // value and enable of an output pin under its io type; reserved types float
    function automatic logic [1:0] pin_type_drv(input logic [2:0] ptype, input logic v);
        case (ptype)
            `CGS_TYPE_PP: pin_type_drv = {v, 1'b1};
            `CGS_TYPE_PP_INV: pin_type_drv = {~v, 1'b1};
            `CGS_TYPE_OPEN_SRC: pin_type_drv = {1'b0, ~v};
            `CGS_TYPE_OPEN_DRN: pin_type_drv = {1'b1, v};
            default: pin_type_drv = 2'h0;
        endcase
    endfunction

    // general output state: {level, enable, weak pull-down}
    function automatic logic [2:0] gp_state(input logic [2:0] code);
        case (code)
            `CGS_GP_WEAK_PD: gp_state = 3'h1;
            `CGS_GP_LOW: gp_state = 3'h2;
            `CGS_GP_HIGH: gp_state = 3'h6;
            default: gp_state = 3'h0;
        endcase
    endfunction

    // serial link: shift in msb first while latch is low; the word stays put
    // while latch is high because the shift is gated off by the latch, clock or no clock
    always_comb begin
        lk_nxt = lk_r;
        if (!serial_latch_i) begin
            lk_nxt.shreg = {lk_r.shreg[30:0], serial_data_i};
        end
    end

    always_ff @(posedge serial_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    // core next state; ce_i low freezes everything in this domain
    always_comb begin
        q_nxt = q_r;
        rise = q_r.pin_s2 & ~q_r.pin_prev;
        good = 1'b0;
        bad = 1'b0;
        div_n = osc_div_of(q_r.regs[`CGS_IDX_OSC][`CGS_OSC_DIV_MSB:`CGS_OSC_DIV_LSB]);
        cnt_cfg = q_r.regs[`CGS_IDX_CNT][`CGS_LOCK_CNT_MSB:`CGS_LOCK_CNT_LSB];
        lock_src_val = 1'b0;
        pin_drv = 2'h0;
        gp_drv = 3'h0;
        if (ce_i) begin
            // two synchroniser flops and one edge flop per pin; the first one is never looked at
            q_nxt.pin_s1 = {serial_latch_i, pll_fb_i, pll_ref_i, sync_pin_i, osc_in_i};
            q_nxt.pin_s2 = q_r.pin_s1;
            q_nxt.pin_prev = q_r.pin_s2;

            // latch rising edge commits the serial word to a known register
            if (rise[`CGS_PIN_LATCH]) begin
                for (int k = 0; k < 8; k++) begin
                    if (lk_r.shreg[4:0] == REG_ADDR[k]) begin
                        q_nxt.regs[k] = lk_r.shreg;
                    end
                end
                // reserved capacitor codes are refused, the last good code stays
                if (lk_r.shreg[4:0] == `CGS_ADDR_LOOP_FILT) begin
                    if (lk_r.shreg[`CGS_CAP4_MSB:`CGS_CAP4_LSB] <= `CGS_CAP_MAX) begin
                        q_nxt.cap4 = lk_r.shreg[`CGS_CAP4_MSB:`CGS_CAP4_LSB];
                    end
                    if (lk_r.shreg[`CGS_CAP3_MSB:`CGS_CAP3_LSB] <= `CGS_CAP_MAX) begin
                        q_nxt.cap3 = lk_r.shreg[`CGS_CAP3_MSB:`CGS_CAP3_LSB];
                    end
                end
            end

            // oscillator divider counts rising edges of the oscillator input
            if (rise[`CGS_PIN_OSC]) begin
                if (q_r.osc_cnt >= div_n - 4'h1) begin
                    q_nxt.osc_cnt = 4'h0;
                end else begin
                    q_nxt.osc_cnt = q_r.osc_cnt + 4'h1;
                end
                q_nxt.osc_div = (q_nxt.osc_cnt < {1'b0, div_n[3:1]});
            end
            // a clear bypass bit gives the only divide-by-one path; a set bypass bit selects the divider
            q_nxt.osc_out[0] = q_r.regs[`CGS_IDX_OSC][`CGS_OSC0_BYPASS_BIT] ?
                q_r.osc_div : q_r.pin_s2[`CGS_PIN_OSC];
            q_nxt.osc_out[1] = q_r.regs[`CGS_IDX_OSC][`CGS_OSC1_BYPASS_BIT] ?
                q_r.osc_div : q_r.pin_s2[`CGS_PIN_OSC];

            // sync request: pin under its polarity, or forced until lock
            q_nxt.sync_act = (q_r.pin_s2[`CGS_PIN_SYNC] ^
                q_r.regs[`CGS_IDX_SYNC][`CGS_SYNC_POL_BIT]) |
                (q_r.regs[`CGS_IDX_LOCK][`CGS_HOLD_SYNC_BIT] & ~q_r.lock);

            // each group keeps its own phase, so excluding one later never
            // disturbs groups that were aligned by an earlier sync
            for (int g = 0; g < 6; g++) begin
                if (q_r.sync_act && !q_r.regs[`CGS_IDX_SYNC][`CGS_GRP_EXCL_LSB + g]) begin
                    q_nxt.grp[g] = 1'b0;
                end else if (rise[`CGS_PIN_OSC]) begin
                    q_nxt.grp[g] = ~q_r.grp[g];
                end
            end

            // sync pin pull selection and crystal amplifier
            q_nxt.sync_pu = q_r.regs[`CGS_IDX_SYNC][`CGS_SYNC_TYPE_MSB:`CGS_SYNC_TYPE_LSB]
                == `CGS_SYNC_PULL_UP;
            q_nxt.sync_pd = q_r.regs[`CGS_IDX_SYNC][`CGS_SYNC_TYPE_MSB:`CGS_SYNC_TYPE_LSB]
                == `CGS_SYNC_PULL_DOWN;
            q_nxt.xtal_en = q_r.regs[`CGS_IDX_SYNC][`CGS_XTAL_EN_BIT];

            // lock detector: feedback must rise within the window of each reference edge
            if (rise[`CGS_PIN_FB]) begin
                q_nxt.fb_age = 4'h0;
            end else if (q_r.fb_age != 4'hf) begin
                q_nxt.fb_age = q_r.fb_age + 4'h1;
            end
            case (q_r.dld_st)
                DLD_IDLE: begin
                    if (rise[`CGS_PIN_REF]) begin
                        if (rise[`CGS_PIN_FB] || q_r.fb_age <= WIN_CYC) begin
                            good = 1'b1;
                        end else begin
                            q_nxt.dld_st = DLD_WAIT;
                            q_nxt.win_cnt = 4'h0;
                        end
                    end
                end
                DLD_WAIT: begin
                    if (rise[`CGS_PIN_FB]) begin
                        good = 1'b1;
                        q_nxt.dld_st = DLD_IDLE;
                    end else if (rise[`CGS_PIN_REF]) begin
                        bad = 1'b1;
                        q_nxt.win_cnt = 4'h0;
                    end else if (q_r.win_cnt >= WIN_CYC) begin
                        bad = 1'b1;
                        q_nxt.dld_st = DLD_IDLE;
                    end else begin
                        q_nxt.win_cnt = q_r.win_cnt + 4'h1;
                    end
                end
                default: q_nxt.dld_st = DLD_IDLE;
            endcase
            // a count of zero is reserved and never reaches lock
            if (bad) begin
                q_nxt.good_cnt = 14'h0000;
                q_nxt.lock = 1'b0;
            end else if (good) begin
                if (q_r.good_cnt != 14'h3fff) begin
                    q_nxt.good_cnt = q_r.good_cnt + 14'h0001;
                end
                q_nxt.lock = (q_nxt.good_cnt >= cnt_cfg) && (cnt_cfg != 14'h0000);
            end
            if (rise[`CGS_PIN_FB]) begin
                q_nxt.n_half = ~q_r.n_half;
            end
            if (rise[`CGS_PIN_REF]) begin
                q_nxt.r_half = ~q_r.r_half;
            end

            // test and lock pin
            case (q_r.regs[`CGS_IDX_LOCK][`CGS_LOCK_SRC_MSB:`CGS_LOCK_SRC_LSB])
                `CGS_SRC_DLD: lock_src_val = q_r.lock;
                `CGS_SRC_N: lock_src_val = q_r.pin_s2[`CGS_PIN_FB];
                `CGS_SRC_N_HALF: lock_src_val = q_r.n_half;
                `CGS_SRC_R: lock_src_val = q_r.pin_s2[`CGS_PIN_REF];
                `CGS_SRC_R_HALF: lock_src_val = q_r.r_half;
                default: lock_src_val = 1'b0;
            endcase
            pin_drv = pin_type_drv(
                q_r.regs[`CGS_IDX_LOCK][`CGS_PIN_TYPE_MSB:`CGS_PIN_TYPE_LSB], lock_src_val);
            q_nxt.lock_pin = pin_drv[1];
            q_nxt.lock_oe = pin_drv[0];

            // readback pin presents the lock status in its own io type
            pin_drv = pin_type_drv(
                q_r.regs[`CGS_IDX_RB][`CGS_PIN_TYPE_MSB:`CGS_PIN_TYPE_LSB], q_r.lock);
            q_nxt.rb_pin = pin_drv[1];
            q_nxt.rb_oe = pin_drv[0];

            // general purpose pins
            gp_drv = gp_state(q_r.regs[`CGS_IDX_RB][`CGS_GP0_MSB:`CGS_GP0_LSB]);
            q_nxt.gp_pin[0] = gp_drv[2];
            q_nxt.gp_oe[0] = gp_drv[1];
            q_nxt.gp_pd[0] = gp_drv[0];
            gp_drv = gp_state(q_r.regs[`CGS_IDX_GP1][`CGS_PIN_TYPE_MSB:`CGS_PIN_TYPE_LSB]);
            q_nxt.gp_pin[1] = gp_drv[2];
            q_nxt.gp_oe[1] = gp_drv[1];
            q_nxt.gp_pd[1] = gp_drv[0];
        end
    end

    // core registers; reset loads constants only
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q_r <= '0;
            q_r.regs <= {`CGS_RST_CNT, `CGS_RST_LF, `CGS_RST_FIXED, `CGS_RST_GP1,
                `CGS_RST_RB, `CGS_RST_LOCK, `CGS_RST_SYNC, `CGS_RST_OSC};
            q_r.dld_st <= DLD_IDLE;
        end else begin
            q_r <= q_nxt;
        end
    end

    // outputs straight from flops
    assign osc_out_o = q_r.osc_out;
    assign group_clk_o = q_r.grp;
    assign sync_pull_up_o = q_r.sync_pu;
    assign sync_pull_down_o = q_r.sync_pd;
    assign crystal_amp_enable_o = q_r.xtal_en;
    assign digital_lock_detect_o = q_r.lock;
    assign test_lock_pin_o = q_r.lock_pin;
    assign test_lock_pin_oe_o = q_r.lock_oe;
    assign readback_pin_o = q_r.rb_pin;
    assign readback_pin_oe_o = q_r.rb_oe;
    assign general_out_o = q_r.gp_pin;
    assign general_out_oe_o = q_r.gp_oe;
    assign general_out_pulldown_o = q_r.gp_pd;
    assign filter_cap_fourth_select_o = q_r.cap4;
    assign filter_cap_third_select_o = q_r.cap3;

    default clocking cb_m @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // a miss takes lock down one edge later and keeps it down for the next,
    // unless the check right after the miss was good under a count of one
    sequence s_miss;
        ce_i && bad;
    endsequence
    sequence s_low_two;
        !digital_lock_detect_o ##1 (!digital_lock_detect_o || $past(good));
    endsequence

    // a freshly lowered ratio may leave the count high until the next input edge wraps it
    div_range_a: assert property (ce_i && rise[`CGS_PIN_OSC] |=>
        q_r.osc_cnt < $past(div_n))
        else $error("oscillator divider count out of range");
    sync_low_a: assert property (ce_i && q_r.sync_act &&
        !q_r.regs[`CGS_IDX_SYNC][`CGS_GRP_EXCL_LSB] |=> !group_clk_o[0])
        else $error("included group not held low during sync");
    excl_toggle_a: assert property (ce_i && rise[`CGS_PIN_OSC] &&
        q_r.regs[`CGS_IDX_SYNC][`CGS_GRP_EXCL_LSB + 5] |=> group_clk_o[5] != $past(group_clk_o[5]))
        else $error("excluded group stopped during sync");
    sync_pol_a: assert property (ce_i && q_r.regs[`CGS_IDX_SYNC][`CGS_SYNC_POL_BIT] &&
        !q_r.pin_s2[`CGS_PIN_SYNC] |=> q_r.sync_act)
        else $error("active low sync not seen");
    hold_sync_a: assert property (ce_i && q_r.regs[`CGS_IDX_LOCK][`CGS_HOLD_SYNC_BIT] &&
        !q_r.lock |=> q_r.sync_act)
        else $error("sync not forced before lock");
    lock_inv_a: assert property (ce_i && q_r.regs[`CGS_IDX_LOCK][31:24] ==
        {`CGS_SRC_LOW, `CGS_TYPE_PP_INV} |=> test_lock_pin_o && test_lock_pin_oe_o)
        else $error("inverted low source not driven high");
    gp0_high_a: assert property (ce_i &&
        q_r.regs[`CGS_IDX_RB][`CGS_GP0_MSB:`CGS_GP0_LSB] == `CGS_GP_HIGH
        |=> general_out_o[0] && general_out_oe_o[0] && !general_out_pulldown_o[0])
        else $error("general output 0 not driven high");
    cap_range_a: assert property (filter_cap_fourth_select_o <= `CGS_CAP_MAX &&
        filter_cap_third_select_o <= `CGS_CAP_MAX)
        else $error("reserved filter capacitor code applied");
    lock_drop_a: assert property (s_miss |=> s_low_two)
        else $error("lock survived a phase miss");
    lock_count_a: assert property ($rose(digital_lock_detect_o) |->
        q_r.good_cnt >= cnt_cfg && cnt_cfg != 14'h0000)
        else $error("lock rose before the programmed count");

    // pin modes follow their fields one edge later
    pull_excl_a: assert property (!(sync_pull_up_o && sync_pull_down_o))
        else $error("sync pin pulled both ways");
    xtal_follow_a: assert property (ce_i |=>
        crystal_amp_enable_o == $past(q_r.regs[`CGS_IDX_SYNC][`CGS_XTAL_EN_BIT]))
        else $error("crystal amplifier does not follow its enable bit");
    lock_src_a: assert property (ce_i && q_r.regs[`CGS_IDX_LOCK][31:24] ==
        {`CGS_SRC_DLD, `CGS_TYPE_PP} |=> test_lock_pin_o == $past(q_r.lock))
        else $error("lock status not routed to the lock pin");
    rb_inv_a: assert property (ce_i &&
        q_r.regs[`CGS_IDX_RB][`CGS_PIN_TYPE_MSB:`CGS_PIN_TYPE_LSB] == `CGS_TYPE_PP_INV
        |=> readback_pin_o != $past(q_r.lock) && readback_pin_oe_o)
        else $error("inverted readback pin does not invert the lock status");
    gp1_high_a: assert property (ce_i &&
        q_r.regs[`CGS_IDX_GP1][`CGS_PIN_TYPE_MSB:`CGS_PIN_TYPE_LSB] == `CGS_GP_HIGH
        |=> general_out_o[1] && general_out_oe_o[1] && !general_out_pulldown_o[1])
        else $error("general output 1 not driven high");
    // a refused code must leave the capacitor select where it was, not clear it
    cap_hold_a: assert property (ce_i && rise[`CGS_PIN_LATCH] &&
        lk_r.shreg[4:0] == `CGS_ADDR_LOOP_FILT &&
        lk_r.shreg[`CGS_CAP4_MSB:`CGS_CAP4_LSB] > `CGS_CAP_MAX
        |=> $stable(filter_cap_fourth_select_o))
        else $error("reserved filter capacitor code changed the select");
    bypass_a: assert property (ce_i &&
        !q_r.regs[`CGS_IDX_OSC][`CGS_OSC0_BYPASS_BIT] |=>
        osc_out_o[0] == $past(q_r.pin_s2[`CGS_PIN_OSC]))
        else $error("bypassed output does not follow the oscillator input");
endmodule

// ---- tb/cgs_host_model.sv ----
// host side of the three-wire serial port: writes whole 32-bit words
// assumes a 20 ns system clock; the 6 ns link clock runs only inside frames
`timescale 1ns/100ps

module cgs_host_model (
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic serial_latch_o
);
    // idle: latch low, link clock stopped
    initial begin
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        serial_latch_o = 1'b0;
    end

    // msb first, address in the low five bits; data moves only while the clock is low
    task automatic send(input logic [31:0] word);
        for (int i = 31; i >= 0; i--) begin
            serial_data_o = word[i];
            #3 serial_clk_o = 1'b1;
            #3 serial_clk_o = 1'b0;
        end
        serial_data_o = ~word[0]; // line driven to the inverse of the last bit, so that bit is not left on it
        #1.7 serial_latch_o = 1'b1;
        #200 serial_latch_o = 1'b0; // ten system cycles, well over the three needed
    endtask
endmodule

// ---- tb/cgs_top_tb_top.sv ----
// self-checking bench of the clock generator configuration block
// assumes cgs_top and cgs_host_model; no randomness
`timescale 1ns/100ps

module cgs_top_tb_top;
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, osc_in_i = 1'b0, sync_pin_i = 1'b0;
    logic pll_ref_i = 1'b0, pll_fb_i = 1'b0, fb_en = 1'b0, sck, sdat, slat;
    logic sync_pull_up_o, sync_pull_down_o, crystal_amp_enable_o, digital_lock_detect_o;
    logic test_lock_pin_o, test_lock_pin_oe_o, readback_pin_o, readback_pin_oe_o;
    logic [1:0] osc_out_o, general_out_o, general_out_oe_o, general_out_pulldown_o;
    logic [5:0] group_clk_o, grp_hi;
    logic [3:0] filter_cap_fourth_select_o, filter_cap_third_select_o;
    logic [2:0] ph = 3'h0;
    int fail_count = 0, n_checks = 0, n_o0, n_o1, n_g0;

    cgs_top i_cgs_top (.mclk_i, .sys_rst_i, .ce_i, .serial_clk_i(sck), .serial_data_i(sdat),
        .serial_latch_i(slat), .osc_in_i, .sync_pin_i, .pll_ref_i, .pll_fb_i, .osc_out_o,
        .group_clk_o, .sync_pull_up_o, .sync_pull_down_o, .crystal_amp_enable_o,
        .digital_lock_detect_o, .test_lock_pin_o, .test_lock_pin_oe_o, .readback_pin_o,
        .readback_pin_oe_o, .general_out_o, .general_out_oe_o, .general_out_pulldown_o,
        .filter_cap_fourth_select_o, .filter_cap_third_select_o);
    cgs_host_model i_cgs_host_model (.serial_clk_o(sck), .serial_data_o(sdat),
        .serial_latch_o(slat));

    // 20 ns system clock
    always #10 mclk_i = ~mclk_i;
    // oscillator of four cycles; reference pulses every eighth cycle, feedback with it once fb_en is set
    always @(posedge mclk_i) begin
        ph <= ph + 3'h1;
        osc_in_i <= ph[1];
        pll_ref_i <= (ph == 3'h0);
        pll_fb_i <= fb_en & (ph == 3'h0);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one write, then settle time so a divider left mid-count has wrapped
    task automatic wr(input logic [31:0] word);
        i_cgs_host_model.send(word);
        repeat (64) @(negedge mclk_i);
    endtask

    // rising edges of both oscillator outputs and group 0, and which groups went high
    task automatic watch(input int cyc);
        logic [2:0] p;
        p = {group_clk_o[0], osc_out_o};
        n_o0 = 0;
        n_o1 = 0;
        n_g0 = 0;
        grp_hi = 6'h00;
        repeat (cyc) begin
            @(negedge mclk_i);
            n_o0 += (osc_out_o[0] && !p[0]);
            n_o1 += (osc_out_o[1] && !p[1]);
            n_g0 += (group_clk_o[0] && !p[2]);
            grp_hi |= group_clk_o;
            p = {group_clk_o[0], osc_out_o};
        end
    endtask

    task automatic sync_set(input logic v);
        @(posedge mclk_i);
        sync_pin_i <= v;
        repeat (16) @(negedge mclk_i);
        watch(200);
    endtask

    task automatic t_reset();
        check(test_lock_pin_o, 1'b0, "lock pin");
        check(test_lock_pin_oe_o, 1'b1, "lock oe");
        check({general_out_oe_o, general_out_o}, 4'hc, "gp low");
        wr(32'h0000_0010);
    endtask

    task automatic t_pins();
        wr(32'h0000_102b);
        check(crystal_amp_enable_o, 1'b1, "xtal on");
        check({sync_pull_up_o, sync_pull_down_o}, 2'b10, "pull-up");
        wr(32'h0000_200b);
        check(crystal_amp_enable_o, 1'b0, "xtal off");
        check({sync_pull_up_o, sync_pull_down_o}, 2'b01, "pull-down");
        wr(32'h0304_000d);
        wr(32'h0400_000e);
        check({general_out_oe_o, general_out_o}, 4'hf, "gp high");
        wr(32'h0302_000d);
        wr(32'h0200_000e);
        check(general_out_pulldown_o, 2'b11, "gp weak");
        wr(32'hdd00_0018);
        wr(32'hef00_0018);
        check(filter_cap_fourth_select_o, 4'hd, "cap4 kept");
        check(filter_cap_third_select_o, 4'hd, "cap3 kept");
    endtask

    // hold-until-lock with the lock status routed to the lock pin
    task automatic t_lock();
        wr(32'h0400_000c);
        check({test_lock_pin_oe_o, test_lock_pin_o}, 2'b11, "low inverted");
        wr(32'h1380_000c);
        watch(100);
        check({digital_lock_detect_o, test_lock_pin_o}, 2'b00, "unlocked");
        check(grp_hi, 6'h00, "sync forced");
        @(posedge mclk_i);
        fb_en <= 1'b1;
        watch(100);
        watch(100);
        check({digital_lock_detect_o, test_lock_pin_o}, 2'b11, "locked");
        check(grp_hi, 6'h3f, "sync released");
        check({readback_pin_oe_o, readback_pin_o}, 2'b11, "rb");
        wr(32'h0403_000d);
        check({readback_pin_oe_o, readback_pin_o}, 2'b10, "rb inverted");
    endtask

    task automatic t_sync();
        wr(32'h0210_000b);
        sync_set(1'b1);
        check(n_g0, 25, "excluded");
        check(grp_hi[5:1], 5'h10, "held low");
        sync_set(1'b0);
        check(grp_hi, 6'h3f, "released");
        wr(32'h0001_000b);
        watch(200);
        check(grp_hi, 6'h00, "active low");
        sync_set(1'b1);
        check(grp_hi, 6'h3f, "idle high");
    endtask

    // each divider code, output 0 divided and output 1 bypassed, over 840 oscillator periods
    task automatic t_div();
        int dv;
        for (int c = 0; c < 8; c++) begin
            dv = (c == 0) ? 8 : (c == 1) ? 2 : c;
            wr(32'h0010_000a | (c << 16));
            watch(3360);
            check(n_o0, 840 / dv, "divided");
            check(n_o1, 840, "bypass");
        end
    endtask

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(negedge mclk_i);
        t_reset();
        t_pins();
        t_lock();
        t_sync();
        t_div();
        end_sim();
    end

    // a hang is cut short here
    initial begin
        #2_000_000;
        fail_count++;
        end_sim();
    end
endmodule
